// File: rtl/qrc_pkg.sv
/*
  shared constants and types for the quasi-resonant switch controller.
  assumes a single 25 MHz core clock; all times are turned into cycles here.
*/
package qrc_pkg;

  // ------------------------------------------------------------
  // clock
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40; // 25 MHz core clock

  // ------------------------------------------------------------
  // times, in their own units, and derived cycle counts
  // ------------------------------------------------------------
  localparam int SS_TIME_MS = 12; // whole soft-start period
  localparam int SS_STEPS = 4; // number of limit steps
  localparam int SS_STEP_CYC = SS_TIME_MS * 1000000 / CLK_PERIOD_NS / SS_STEPS;
  localparam int EVAL_TIME_MS = 48; // up/down counter evaluation period
  localparam int EVAL_CYC = EVAL_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OVP_TIME_US = 100; // overvoltage persistence, least time
  localparam int OVP_CYC = (OVP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_OFF_TIME_US = 50; // keeps switching above 20 kHz, longest time
  localparam int MAX_OFF_CYC = MAX_OFF_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int MAX_ON_TIME_NS = 22000; // longest on time
  localparam int MAX_ON_CYC = MAX_ON_TIME_NS / CLK_PERIOD_NS;
  localparam int LEB_TIME_NS = 220; // leading edge blanking, least time
  localparam int LEB_CYC = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RING_SHORT_TIME_NS = 2500; // short ringing suppression
  localparam int RING_SHORT_CYC = (RING_SHORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RING_LONG_TIME_NS = 5000; // long ringing suppression
  localparam int RING_LONG_CYC = (RING_LONG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // counter widths and limits
  // ------------------------------------------------------------
  localparam int TMR_W = 12; // short timers, all counts below 4096
  localparam logic [2:0] UD_MIN = 3'h1; // up/down counter floor
  localparam logic [2:0] UD_MAX = 3'h7; // up/down counter ceiling
  localparam logic [2:0] VALLEY_MAX = 3'h7; // valley counter ceiling
  localparam logic [2:0] VALLEY_CLR = 3'h0; // valley counter after turn-on
  localparam logic [1:0] SS_FIRST = 2'h0; // lowest soft-start limit step
  localparam logic [1:0] SS_LAST = 2'h3; // full limit step

  // ------------------------------------------------------------
  // comparator pin bit positions
  // ------------------------------------------------------------
  localparam int PIN_FB_LOW = 0;
  localparam int PIN_FB_HIGH = 1;
  localparam int PIN_FB_FAST = 2;
  localparam int PIN_AUX_VALLEY = 3;
  localparam int PIN_AUX_OVP = 4;
  localparam int PIN_AUX_RING = 5;
  localparam int PIN_SENSE_FB = 6;
  localparam int PIN_SENSE_LIM = 7;
  localparam int PIN_LINE_HIGH = 8;
  localparam int PIN_N = 9;

  // ------------------------------------------------------------
  // switching states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    QRC_ST_OFF = 2'b00,
    QRC_ST_ON = 2'b01,
    QRC_ST_LATCH = 2'b10
  } qrc_state_t;

endpackage

// File: rtl/qrc_pin_if.sv
/*
  carrier for the comparator pins between the top and the synchroniser.
  assumes raw levels are asynchronous to sys_clk.
*/
`timescale 1ns/1ns
interface qrc_pin_if #(parameter int W = 9);
  logic [W-1:0] raw; // asynchronous comparator levels
  logic [W-1:0] clean; // filtered, clock-aligned levels
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

// File: rtl/qrc_pin_sync.sv
/*
  three-stage synchroniser with agreement filter, one per comparator pin.
  assumes the carrier interface raw levels are asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module qrc_pin_sync #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // pins
  qrc_pin_if.sync pins
);

  // ------------------------------------------------------------
  // stages
  // ------------------------------------------------------------
  logic [W-1:0] s1_q; // first stage, read only by s2
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q; // accepted level
  logic [W-1:0] clean_d;

  // accept a change once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
    end
  end

  // register the chain
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign pins.clean = clean_q;

endmodule

// File: rtl/qrc_switch_ctrl.sv
/*
  quasi-resonant flyback switch controller core: soft-start, valley
  selection, ringing suppression, on/off time limits, overvoltage latch.
  assumes analog comparators outside; their results arrive asynchronously.
*/
`timescale 1ns/1ns
// Operation
// [RULE1] soft-start limit rises in four steps
// [RULE2] valleys turn on, current sense turns off
// [RULE3] three feedback thresholds, one update per period
// [RULE4] always below low: count up to seven
// [RULE5] above low only: counter holds
// [RULE6] above high, not fast: count down
// [RULE7] fast-reset threshold forces counter to one
// [RULE8] counter stays between one and seven
// [RULE9] counter starts at one
// [RULE10] line level selects hysteresis thresholds
// [RULE11] count falling valley crossings while off
// [RULE12] valley counter clears at each turn-on
// [RULE13] persistent overvoltage while off latches off
// [RULE14] overvoltage must persist one hundred microseconds
// [RULE15] ringing suppression length from aux level
// [RULE16] no turn-on during ringing suppression
// [RULE17] turn on when valleys reach counter
// [RULE18] maximum off time forces turn-on
// [RULE19] sensed current above feedback turns off
// [RULE20] blank current sense after turn-on
// [RULE21] maximum on time forces turn-off
// [RULE22] sticky threshold flags per period
// [RULE23] equal soft-start steps, final level holds
module qrc_switch_ctrl
  import qrc_pkg::*;
#(
  parameter int SS_STEP_CYCLES = qrc_pkg::SS_STEP_CYC,
  parameter int EVAL_CYCLES = qrc_pkg::EVAL_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // feedback comparators
  input wire logic fb_above_low_hyst,
  input wire logic fb_above_high_hyst,
  input wire logic fb_above_fast_reset,
  // auxiliary-sense comparators
  input wire logic aux_below_valley,
  input wire logic aux_above_ovp,
  input wire logic aux_above_ringing_select,
  // current-sense comparators
  input wire logic sense_above_feedback,
  input wire logic sense_above_softstart_limit,
  // line level detector
  input wire logic line_high,
  // gate drive, analog steering and latch-off status
  output logic gate_drive,
  output logic [1:0] softstart_step,
  output logic hyst_thresh_sel,
  output logic latched_off
);
  import qrc_pkg::*;

  localparam int SSW = $clog2(SS_STEP_CYCLES);
  localparam int EVW = $clog2(EVAL_CYCLES);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  qrc_pin_if #(.W(PIN_N)) pins ();

  assign pins.raw[PIN_FB_LOW] = fb_above_low_hyst;
  assign pins.raw[PIN_FB_HIGH] = fb_above_high_hyst;
  assign pins.raw[PIN_FB_FAST] = fb_above_fast_reset;
  assign pins.raw[PIN_AUX_VALLEY] = aux_below_valley;
  assign pins.raw[PIN_AUX_OVP] = aux_above_ovp;
  assign pins.raw[PIN_AUX_RING] = aux_above_ringing_select;
  assign pins.raw[PIN_SENSE_FB] = sense_above_feedback;
  assign pins.raw[PIN_SENSE_LIM] = sense_above_softstart_limit;
  assign pins.raw[PIN_LINE_HIGH] = line_high;

  qrc_pin_sync #(.W(PIN_N)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pins(pins)
  );

  // clean levels by name
  logic fb_low, fb_high, fb_fast, aux_valley, aux_ovp, aux_ring, sense_fb, sense_lim;
  assign fb_low = pins.clean[PIN_FB_LOW];
  assign fb_high = pins.clean[PIN_FB_HIGH];
  assign fb_fast = pins.clean[PIN_FB_FAST];
  assign aux_valley = pins.clean[PIN_AUX_VALLEY];
  assign aux_ovp = pins.clean[PIN_AUX_OVP];
  assign aux_ring = pins.clean[PIN_AUX_RING];
  assign sense_fb = pins.clean[PIN_SENSE_FB];
  assign sense_lim = pins.clean[PIN_SENSE_LIM];

  // ------------------------------------------------------------
  // switching state
  // ------------------------------------------------------------
  qrc_state_t state_q, state_d; // off, on or latched
  logic gate_q, gate_d, latch_q, latch_d; // gate drive and latch-off flops
  logic [TMR_W-1:0] on_q, on_d; // cycles since turn-on
  logic [TMR_W-1:0] off_q, off_d; // cycles since turn-off
  logic [TMR_W-1:0] ring_q, ring_d; // suppression cycles left
  logic [TMR_W-1:0] ovp_q, ovp_d; // overvoltage persistence
  logic [2:0] valley_q, valley_d; // valley counter
  logic valley_prev_q; // previous valley comparator level
  logic [2:0] ud_q, ud_d; // valley to switch on at
  logic turn_on, turn_off, ovp_hit, blank_done;

  // decide the next switching event
  always_comb begin
    state_d = state_q;
    on_d = on_q;
    off_d = off_q;
    ring_d = ring_q;
    ovp_d = ovp_q;
    valley_d = valley_q;
    turn_on = 1'b0;
    turn_off = 1'b0;
    blank_done = (on_q >= TMR_W'(LEB_CYC)); // [RULE20]
    ovp_hit = 1'b0;
    case (state_q)
      QRC_ST_OFF: begin
        // overvoltage must persist while off; the count holds over on-times, where the pin is clamped
        if (aux_ovp) begin
          ovp_d = ovp_q + 1'b1;
          ovp_hit = (ovp_q == TMR_W'(OVP_CYC - 1)); // [RULE13] [RULE14]
        end else begin
          ovp_d = '0;
        end
        // suppression countdown
        if (ring_q != '0) begin
          ring_d = ring_q - 1'b1;
        end
        // off-time counter saturates at the limit
        if (off_q != TMR_W'(MAX_OFF_CYC - 1)) begin
          off_d = off_q + 1'b1;
        end
        // falling crossing below the valley threshold
        if (aux_valley && !valley_prev_q && valley_q != VALLEY_MAX) begin
          valley_d = valley_q + 1'b1; // [RULE11]
        end
        if (ovp_hit) begin
          state_d = QRC_ST_LATCH; // [RULE13]
        end else if (ring_q == '0) begin // [RULE16]
          if (valley_q >= ud_q || off_q == TMR_W'(MAX_OFF_CYC - 1)) begin // [RULE17] [RULE18] [RULE2]
            turn_on = 1'b1;
          end
        end
        if (turn_on) begin
          state_d = QRC_ST_ON;
          on_d = '0;
          valley_d = VALLEY_CLR; // [RULE12]
        end
      end
      QRC_ST_ON: begin
        on_d = on_q + 1'b1;
        if (on_q == TMR_W'(MAX_ON_CYC - 1)) begin
          turn_off = 1'b1; // [RULE21]
        end else if (blank_done && (sense_fb || sense_lim)) begin
          turn_off = 1'b1; // [RULE19] [RULE2] [RULE1]
        end
        if (turn_off) begin
          state_d = QRC_ST_OFF;
          off_d = '0;
          // longer suppression while aux stays low
          ring_d = aux_ring ? TMR_W'(RING_SHORT_CYC) : TMR_W'(RING_LONG_CYC); // [RULE15]
        end
      end
      QRC_ST_LATCH: begin
        state_d = QRC_ST_LATCH; // held until the next reset
      end
      default: begin
        state_d = QRC_ST_OFF;
      end
    endcase
    gate_d = (state_d == QRC_ST_ON);
    latch_d = (state_d == QRC_ST_LATCH);
  end

  // register the switching state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= QRC_ST_OFF;
      gate_q <= 1'b0;
      latch_q <= 1'b0;
      on_q <= '0;
      off_q <= '0;
      ring_q <= '0;
      ovp_q <= '0;
      valley_q <= VALLEY_CLR;
      valley_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gate_q <= gate_d;
      latch_q <= latch_d;
      on_q <= on_d;
      off_q <= off_d;
      ring_q <= ring_d;
      ovp_q <= ovp_d;
      valley_q <= valley_d;
      valley_prev_q <= aux_valley;
    end
  end

  // ------------------------------------------------------------
  // up/down counter and evaluation period
  // ------------------------------------------------------------
  logic [EVW-1:0] eval_q, eval_d; // position in the period
  logic seen_low_q, seen_low_d; // sticky: above low threshold
  logic seen_high_q, seen_high_d; // sticky: above high threshold
  logic seen_fast_q, seen_fast_d; // sticky: above fast-reset threshold
  logic hyst_q, hyst_d; // threshold set for line level
  logic any_low, any_high, any_fast;

  // evaluate the feedback once per period; fast reset also acts in any cycle
  always_comb begin
    ud_d = ud_q;
    eval_d = eval_q + 1'b1;
    any_low = seen_low_q | fb_low;
    any_high = seen_high_q | fb_high;
    any_fast = seen_fast_q | fb_fast;
    seen_low_d = any_low; // [RULE22]
    seen_high_d = any_high;
    seen_fast_d = any_fast;
    hyst_d = pins.clean[PIN_LINE_HIGH]; // [RULE10]
    if (eval_q == EVW'(EVAL_CYCLES - 1)) begin // [RULE3]
      eval_d = '0;
      if (any_fast) begin
        ud_d = UD_MIN; // [RULE7]
      end else if (any_high) begin
        if (ud_q != UD_MIN) begin
          ud_d = ud_q - 1'b1; // [RULE6] [RULE8]
        end
      end else if (any_low) begin
        ud_d = ud_q; // [RULE5]
      end else if (ud_q != UD_MAX) begin
        ud_d = ud_q + 1'b1; // [RULE4] [RULE8]
      end
      // restart flags; a level present now is kept for the next period
      seen_low_d = fb_low; // [RULE22]
      seen_high_d = fb_high;
      seen_fast_d = fb_fast;
    end
    if (fb_fast) begin
      ud_d = UD_MIN; // [RULE7]
    end
  end

  // register the counter group
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ud_q <= UD_MIN; // [RULE9]
      eval_q <= '0;
      seen_low_q <= 1'b0;
      seen_high_q <= 1'b0;
      seen_fast_q <= 1'b0;
      hyst_q <= 1'b0;
    end else begin
      ud_q <= ud_d;
      eval_q <= eval_d;
      seen_low_q <= seen_low_d;
      seen_high_q <= seen_high_d;
      seen_fast_q <= seen_fast_d;
      hyst_q <= hyst_d;
    end
  end

  // ------------------------------------------------------------
  // soft-start limit steps
  // ------------------------------------------------------------
  logic [1:0] ss_q, ss_d; // current limit step
  logic [SSW-1:0] ss_cnt_q, ss_cnt_d; // cycles within the step

  // equal steps, last one holds until reset
  always_comb begin
    ss_d = ss_q;
    ss_cnt_d = ss_cnt_q;
    if (ss_q != SS_LAST) begin
      if (ss_cnt_q == SSW'(SS_STEP_CYCLES - 1)) begin
        ss_cnt_d = '0;
        ss_d = ss_q + 1'b1; // [RULE1] [RULE23]
      end else begin
        ss_cnt_d = ss_cnt_q + 1'b1;
      end
    end
  end

  // register the soft-start group
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ss_q <= SS_FIRST;
      ss_cnt_q <= '0;
    end else begin
      ss_q <= ss_d;
      ss_cnt_q <= ss_cnt_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign gate_drive = gate_q;
  assign softstart_step = ss_q;
  assign hyst_thresh_sel = hyst_q;
  assign latched_off = latch_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_ss_final_hold: assert property (ss_q == SS_LAST |=> ss_q == SS_LAST) // [RULE23]
    else $error("soft-start left its final step");
  a_ss_one_step: assert property (ss_q != $past(ss_q) |-> ss_q == $past(ss_q) + 2'h1) // [RULE1]
    else $error("soft-start step skipped or went back");
  a_ud_in_range: assert property (ud_q >= UD_MIN && ud_q <= UD_MAX) // [RULE8]
    else $error("up/down counter out of range");
  a_fast_reset_one: assert property (fb_fast |=> ud_q == UD_MIN) // [RULE7]
    else $error("fast reset did not force counter to one");
  a_valley_clear_on: assert property ($rose(gate_q) |-> valley_q == VALLEY_CLR) // [RULE12]
    else $error("valley counter not cleared at turn-on");
  a_ring_no_on: assert property ($rose(gate_q) |-> $past(ring_q) == '0) // [RULE16]
    else $error("turned on during ringing suppression");
  a_valley_turn_on: assert property (state_q == QRC_ST_OFF && ring_q == '0 && valley_q >= ud_q && !ovp_hit
    |=> gate_q) // [RULE17]
    else $error("valley reached but gate stayed off");
  a_leb_min_on: assert property ($rose(gate_q) |-> gate_q [*7]) // [RULE20]
    else $error("gate shorter than the blanking interval");
  a_max_on_limit: assert property (gate_q |-> on_q < TMR_W'(MAX_ON_CYC)) // [RULE21]
    else $error("gate exceeded maximum on time");
  a_latch_holds: assert property (state_q == QRC_ST_LATCH |=> state_q == QRC_ST_LATCH && !gate_q) // [RULE13]
    else $error("overvoltage latch released");

endmodule

// File: testbench/qrc_power_stage.sv
/*
  behavioural flyback power stage: shunt comparator and auxiliary-winding valleys.
  assumes gate_drive is registered on sys_clk; settings come from the bench.
*/
`timescale 1ns/1ns
module qrc_power_stage (
  // clock
  input wire logic sys_clk,
  // gate from the controller
  input wire logic gate_drive,
  // stage settings, on_len zero means the shunt never trips
  input wire logic [11:0] on_len,
  input wire logic [11:0] val_start,
  input wire logic [11:0] val_gap,
  input wire logic [3:0] val_n,
  // comparator results back to the controller, valley count to the bench
  output logic sense_above_feedback,
  output logic aux_below_valley,
  output logic [3:0] v_seen
);
  logic [11:0] on_cnt_q = 12'h000; // cycles since the switch closed
  logic [11:0] off_cnt_q = 12'h000; // cycles since the switch opened
  logic [11:0] rel; // off time past the first valley
  assign rel = off_cnt_q - val_start;
  initial begin
    sense_above_feedback = 1'b0;
    aux_below_valley = 1'b0;
    v_seen = 4'h0;
  end
  // ------------------------------------------------------------
  // stage behaviour, one step per clock
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (gate_drive) begin
      // switch closed: current ramps until the shunt level passes feedback
      off_cnt_q <= 12'h000;
      on_cnt_q <= on_cnt_q + 12'h001;
      aux_below_valley <= #1 1'b0;
      sense_above_feedback <= #1 (on_len != 12'h000) && (on_cnt_q >= on_len);
    end else begin
      // switch open: ringing gives val_n valleys, each four cycles wide
      on_cnt_q <= 12'h000;
      off_cnt_q <= off_cnt_q + 12'h001;
      sense_above_feedback <= #1 1'b0;
      aux_below_valley <= #1 (off_cnt_q >= val_start) && (rel / val_gap < val_n) && (rel % val_gap < 12'h004);
      // valleys offered so far in this off time, frozen while on
      if (off_cnt_q < val_start) begin
        v_seen <= 4'h0;
      end else if (rel / val_gap < val_n) begin
        v_seen <= 4'(rel / val_gap + 1);
      end else begin
        v_seen <= val_n;
      end
    end
  end
endmodule

// File: testbench/qrc_switch_ctrl_bench.sv
/*
  self-checking bench for the switch controller with a power stage model.
  assumes short soft-start and evaluation periods set through parameters.
*/
`timescale 1ns/1ns
module qrc_switch_ctrl_bench;
  import qrc_pkg::*;
  // ------------------------------------------------------------
  // settings and signals
  // ------------------------------------------------------------
  localparam int SS_STEP = 20; // shortened soft-start step
  localparam int EVAL = 50; // shortened evaluation period
  localparam int BOUND = 3000; // longest wait for a gate edge
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic fb_low = 1'b1; // keeps the up/down counter at rest
  logic fb_high = 1'b0;
  logic fb_fast = 1'b0;
  logic aux_ovp = 1'b0;
  logic ring_hi = 1'b0;
  logic ss_lim = 1'b0; // soft-start limit never trips here
  logic line_high = 1'b0;
  logic sense_fb, aux_valley, gate_drive, hyst_thresh_sel, latched_off;
  logic [1:0] softstart_step;
  logic [11:0] on_len = 12'h028;
  logic [11:0] val_start = 12'h096;
  logic [11:0] val_gap = 12'h014;
  logic [3:0] val_n = 4'h0;
  logic [3:0] v_seen;
  int n_errors = 0;
  int num_checks = 0;
  int hi_len, off_len;
  // free-running core clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  qrc_switch_ctrl #(.SS_STEP_CYCLES(SS_STEP), .EVAL_CYCLES(EVAL)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .fb_above_low_hyst(fb_low), .fb_above_high_hyst(fb_high), .fb_above_fast_reset(fb_fast),
    .aux_below_valley(aux_valley), .aux_above_ovp(aux_ovp), .aux_above_ringing_select(ring_hi),
    .sense_above_feedback(sense_fb), .sense_above_softstart_limit(ss_lim), .line_high(line_high),
    .gate_drive(gate_drive), .softstart_step(softstart_step), .hyst_thresh_sel(hyst_thresh_sel),
    .latched_off(latched_off)
  );
  qrc_power_stage stage_u (
    .sys_clk(sys_clk), .gate_drive(gate_drive), .on_len(on_len), .val_start(val_start),
    .val_gap(val_gap), .val_n(val_n), .sense_above_feedback(sense_fb), .aux_below_valley(aux_valley),
    .v_seen(v_seen)
  );
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  // step past edges; inputs change and outputs are read 1 ns after
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for the gate to reach a level, counting cycles
  task automatic wait_gate(input logic v, output int n);
    n = 0;
    while (gate_drive !== v && n < BOUND) begin
      tick(1);
      n++;
    end
    if (n >= BOUND) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, gate_drive, v);
      final_report();
    end
  endtask
  // one whole switching cycle: on length, then off length
  task automatic one_cycle;
    int n;
    wait_gate(1'b1, n);
    wait_gate(1'b0, hi_len);
    wait_gate(1'b1, off_len);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_softstart;
    check(latched_off, 1'b0);
    tick(SS_STEP / 2);
    // one step per quarter of the soft-start time
    for (int k = 0; k < 4; k++) begin
      check(softstart_step, k);
      tick(SS_STEP);
    end
    tick(4 * SS_STEP);
    check(softstart_step, SS_LAST);
    $display("test softstart done");
  endtask
  task automatic test_line;
    line_high = 1'b1;
    tick(8);
    check(hyst_thresh_sel, 1'b1);
    line_high = 1'b0;
    tick(8);
    check(hyst_thresh_sel, 1'b0);
    $display("test line select done");
  endtask
  task automatic test_on_off;
    one_cycle();
    check(in_rng(hi_len, 40, 48), 1'b1);
    check(in_rng(off_len, MAX_OFF_CYC - 2, MAX_OFF_CYC + 2), 1'b1);
    on_len = 12'h001;
    one_cycle();
    check(in_rng(hi_len, LEB_CYC + 1, LEB_CYC + 4), 1'b1);
    on_len = 12'h000;
    one_cycle();
    check(in_rng(hi_len, MAX_ON_CYC - 1, MAX_ON_CYC + 1), 1'b1);
    on_len = 12'h028;
    $display("test on and off limits done");
  endtask
  task automatic test_suppress;
    // a single early valley lands inside the suppression time
    val_start = 12'h002;
    val_gap = 12'h12c;
    val_n = 4'h1;
    ring_hi = 1'b1;
    one_cycle();
    check(in_rng(off_len, RING_SHORT_CYC, RING_SHORT_CYC + 8), 1'b1);
    ring_hi = 1'b0;
    one_cycle();
    check(in_rng(off_len, RING_LONG_CYC, RING_LONG_CYC + 8), 1'b1);
    val_start = 12'h0c8;
    one_cycle();
    check(in_rng(off_len, 203, 212), 1'b1);
    // no valley now: a stale count would switch on early
    val_n = 4'h0;
    one_cycle();
    check(in_rng(off_len, MAX_OFF_CYC - 2, MAX_OFF_CYC + 2), 1'b1);
    $display("test ringing suppression done");
  endtask
  task automatic test_updown;
    val_start = 12'h096;
    val_gap = 12'h014;
    val_n = 4'h8;
    one_cycle();
    check(v_seen, UD_MIN);
    fb_low = 1'b0;
    repeat (2) one_cycle();
    check(v_seen, UD_MAX);
    fb_low = 1'b1;
    repeat (2) one_cycle();
    check(v_seen, UD_MAX);
    // short load step across all three thresholds
    fb_high = 1'b1;
    fb_fast = 1'b1;
    tick(5);
    fb_high = 1'b0;
    fb_fast = 1'b0;
    repeat (2) one_cycle();
    check(v_seen, UD_MIN);
    fb_low = 1'b0;
    repeat (2) one_cycle();
    check(v_seen, UD_MAX);
    fb_low = 1'b1;
    fb_high = 1'b1;
    repeat (3) one_cycle();
    check(v_seen, UD_MIN);
    fb_high = 1'b0;
    $display("test up/down counter done");
  endtask
  task automatic test_ovp;
    int n;
    // overvoltage over one off time, shorter than the persistence time
    val_n = 4'h0;
    aux_ovp = 1'b1;
    one_cycle();
    check(latched_off, 1'b0);
    check(softstart_step, SS_LAST);
    // kept up through the next off time, the sum passes the persistence time
    n = 0;
    while (latched_off !== 1'b1 && n < BOUND) begin
      tick(1);
      n++;
    end
    check(latched_off, 1'b1);
    if (latched_off !== 1'b1) begin
      final_report();
    end
    check(hi_len + off_len + n >= OVP_CYC, 1'b1);
    tick(MAX_OFF_CYC + 8);
    check(gate_drive, 1'b0);
    check(latched_off, 1'b1);
    // only a reset clears the latch; soft-start begins again
    arst_n = 1'b0;
    aux_ovp = 1'b0;
    tick(2);
    check(latched_off, 1'b0);
    check(softstart_step, SS_FIRST);
    arst_n = 1'b1;
    tick(SS_STEP + 1);
    check(softstart_step, 2'h1);
    check(gate_drive, 1'b0);
    $display("test overvoltage persistence done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(8);
    arst_n = 1'b1;
    test_softstart();
    test_line();
    test_on_off();
    test_suppress();
    test_updown();
    test_ovp();
    final_report();
  end
endmodule
